// ==== hdl/cfe_pkg.sv ====
// Package for the CAM address filter command engine: register indices,
// status bit positions, instruction codes and reset values.
// Assumes a 16-bit node processor register port and one 25 MHz clock.
package cfe_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int CFE_ENTRIES = 32;
  localparam int CFE_IDX_W = 5;
  localparam int CFE_KEY_W = 48;
  localparam int CFE_PERS_W = 6;

  // ----------------------------------------------------------------
  // Register indices on the node processor port
  // ----------------------------------------------------------------
  localparam logic [3:0] CFE_REG_CMD = 4'h0;
  localparam logic [3:0] CFE_REG_STAT = 4'h1;
  localparam logic [3:0] CFE_REG_SIG = 4'h2;
  localparam logic [3:0] CFE_REG_PERS = 4'h3;
  localparam logic [3:0] CFE_REG_COMP0 = 4'h4;
  localparam logic [3:0] CFE_REG_COMP1 = 4'h5;
  localparam logic [3:0] CFE_REG_COMP2 = 4'h6;
  localparam logic [3:0] CFE_REG_MASK0 = 4'h7;
  localparam logic [3:0] CFE_REG_MASK1 = 4'h8;
  localparam logic [3:0] CFE_REG_MASK2 = 4'h9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFE_CMD_OP_MSB = 2;
  localparam int CFE_STAT_FLAG_LSB = 8;
  localparam int CFE_STAT_REV_LSB = 5;
  localparam int CFE_PERS_VALID = 0;
  localparam int CFE_PERS_SKIP = 1;
  localparam int CFE_PERS_EXACT = 2;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [2:0] CFE_CMD_RST = 3'h0;
  localparam logic [15:0] CFE_WORD_RST = 16'h0000;
  localparam logic [15:0] CFE_SIG_SEED = 16'h0001;
  // Revision number, value is arbitrary
  localparam logic [2:0] CFE_REVISION = 3'h1;
  localparam logic [4:0] CFE_BIST_LAST = 5'h1f;

  // Instruction codes
  typedef enum logic [2:0] {
    CFE_OP_INV_ALL = 3'h0,
    CFE_OP_WRITE = 3'h1,
    CFE_OP_READ = 3'h2,
    CFE_OP_BIST = 3'h3,
    CFE_OP_FIND = 3'h4,
    CFE_OP_INV_ONE = 3'h5,
    CFE_OP_SKIP = 3'h6,
    CFE_OP_CLR_SKIP = 3'h7
  } cfe_op_t;

  // Status flags, packed in the order of status bits 15 down to 8
  typedef struct packed {
    logic done;
    logic full;
    logic found;
    logic exact;
    logic multi_hit_flag;
    logic error;
    logic empty;
    logic self_test_complete_flag;
  } cfe_flags_t;

  localparam cfe_flags_t CFE_FLAGS_RST = '{done: 1'b1, empty: 1'b1, default: 1'b0};

endpackage : cfe_pkg

// ==== hdl/cfe_engine.sv ====
// Command engine of a 32-entry CAM address filter with its node
// processor register file (command, status, signature, operands).
// Assumes the receive-bus matcher runs on the same clock and flags
// its busy window on i_rx_match_busy.
`timescale 1ns/1ps

module cfe_engine (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [3:0] i_reg_sel,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wdata,
  input wire logic i_rx_match_busy,
  output logic [15:0] o_rdata,
  output logic o_done
);
  import cfe_pkg::*;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_EXEC, ST_BIST, ST_FIN} cfe_state_t;

  cfe_state_t state_reg;
  cfe_op_t op_reg;
  cfe_flags_t flags_reg;
  logic [2:0] cmd_reg;
  logic [15:0] sig_reg;
  logic [CFE_PERS_W-1:0] pers_reg;
  logic [CFE_KEY_W-1:0] comp_reg;
  logic [CFE_KEY_W-1:0] mask_reg;
  logic [CFE_ENTRIES-1:0] valid_reg;
  logic [CFE_ENTRIES-1:0] skip_reg;
  logic [CFE_ENTRIES-1:0] hit_reg;
  logic [CFE_IDX_W-1:0] bist_idx_reg;
  logic gate_ok_reg;
  logic [15:0] rdata_reg;
  logic [CFE_KEY_W-1:0] cam_key [CFE_ENTRIES];
  logic [CFE_KEY_W-1:0] cam_mask [CFE_ENTRIES];
  logic [CFE_PERS_W-1:0] cam_pers [CFE_ENTRIES];

  logic cmd_wr;
  logic cmd_start;
  logic [CFE_ENTRIES-1:0] match_vec;
  logic [CFE_IDX_W-1:0] hit_idx;
  logic [CFE_IDX_W-1:0] free_idx;
  logic exact_any;
  logic multi_any;

  assign cmd_wr = i_wr_en && (i_reg_sel == CFE_REG_CMD);
  // Commands only start from idle; the processor waits for done anyway
  assign cmd_start = cmd_wr && (state_reg == ST_IDLE) && !i_rx_match_busy;

  // ----------------------------------------------------------------
  // Parallel compare and priority pickers
  // ----------------------------------------------------------------
  // Node processor mask takes no part; each entry's own mask gates bits
  always_comb begin
    match_vec = '0;
    exact_any = 1'b0;
    for (int i = 0; i < CFE_ENTRIES; i++) begin
      match_vec[i] = valid_reg[i] && !skip_reg[i] &&
        (((cam_key[i] ^ comp_reg) & cam_mask[i]) == '0);
      exact_any = exact_any || (match_vec[i] && cam_pers[i][CFE_PERS_EXACT]);
    end
  end

  // Multi-hit: clearing the lowest set bit still leaves one set
  assign multi_any = |(match_vec & (match_vec - 32'h1));

  // Lowest index wins; loop runs downward so the last write is lowest
  always_comb begin
    hit_idx = '0;
    free_idx = '0;
    for (int i = CFE_ENTRIES - 1; i >= 0; i--) begin
      if (hit_reg[i]) begin
        hit_idx = i[CFE_IDX_W-1:0];
      end
      if (!valid_reg[i]) begin
        free_idx = i[CFE_IDX_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and status flags
  // ----------------------------------------------------------------
  // Issue clears done and result flags; EXEC (BIST for self test) changes the CAM and posts find flags; FIN sets done
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_IDLE;
      op_reg <= CFE_OP_INV_ALL;
      flags_reg <= CFE_FLAGS_RST;
      hit_reg <= '0;
      bist_idx_reg <= '0;
      gate_ok_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (cmd_wr && i_rx_match_busy) begin
            flags_reg.error <= 1'b1;
            flags_reg.done <= 1'b1;
          end else if (cmd_start) begin
            op_reg <= cfe_op_t'(i_wdata[CFE_CMD_OP_MSB:0]);
            state_reg <= ST_EXEC;
            flags_reg.done <= 1'b0;
            flags_reg.found <= 1'b0;
            flags_reg.multi_hit_flag <= 1'b0;
            flags_reg.self_test_complete_flag <= 1'b0;
            flags_reg.exact <= 1'b0;
            case (cfe_op_t'(i_wdata[CFE_CMD_OP_MSB:0]))
              CFE_OP_INV_ALL: begin
                flags_reg.full <= 1'b0;
                flags_reg.error <= 1'b0;
                gate_ok_reg <= 1'b1;
              end
              CFE_OP_WRITE: begin
                flags_reg.full <= 1'b0;
                flags_reg.error <= flags_reg.full;
                gate_ok_reg <= !flags_reg.full;
              end
              CFE_OP_READ: begin
                flags_reg.error <= flags_reg.empty || !flags_reg.found;
                gate_ok_reg <= !flags_reg.empty && flags_reg.found;
              end
              CFE_OP_INV_ONE, CFE_OP_SKIP: begin
                flags_reg.error <= !flags_reg.found;
                gate_ok_reg <= flags_reg.found;
              end
              default: begin
                flags_reg.error <= 1'b0;
                gate_ok_reg <= 1'b1;
              end
            endcase
          end else if (i_wr_en && i_reg_sel == CFE_REG_STAT) begin
            // Software may rewrite flags only while nothing is running
            flags_reg <= cfe_flags_t'(i_wdata[15:CFE_STAT_FLAG_LSB]);
          end
        end
        ST_EXEC: begin
          state_reg <= ST_FIN;
          case (op_reg)
            CFE_OP_FIND: begin
              hit_reg <= match_vec;
              flags_reg.found <= |match_vec;
              flags_reg.multi_hit_flag <= multi_any;
              flags_reg.exact <= exact_any;
            end
            CFE_OP_BIST: begin
              bist_idx_reg <= '0;
              state_reg <= ST_BIST;
            end
            CFE_OP_INV_ALL: begin
              hit_reg <= '0;
            end
            default: begin
            end
          endcase
        end
        ST_BIST: begin
          // Walks every entry once, one per cycle
          bist_idx_reg <= bist_idx_reg + 5'h1;
          if (bist_idx_reg == CFE_BIST_LAST) begin
            hit_reg <= '0;
            state_reg <= ST_FIN;
          end
        end
        ST_FIN: begin
          state_reg <= ST_IDLE;
          flags_reg.done <= 1'b1;
          case (op_reg)
            CFE_OP_INV_ALL, CFE_OP_WRITE, CFE_OP_INV_ONE: begin
              flags_reg.empty <= ~|valid_reg;
              flags_reg.full <= &valid_reg;
            end
            CFE_OP_BIST: begin
              flags_reg.self_test_complete_flag <= 1'b1;
            end
            default: begin
            end
          endcase
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // CAM array
  // ----------------------------------------------------------------
  // Valid and skip marks reset; entry data is plain memory, no reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      valid_reg <= '0;
      skip_reg <= '0;
    end else if (state_reg == ST_EXEC && gate_ok_reg) begin
      case (op_reg)
        CFE_OP_INV_ALL: begin
          valid_reg <= '0;
          skip_reg <= '0;
        end
        CFE_OP_WRITE: begin
          valid_reg[free_idx] <= 1'b1;
          skip_reg[free_idx] <= 1'b0;
        end
        CFE_OP_INV_ONE: begin
          valid_reg[hit_idx] <= 1'b0;
        end
        CFE_OP_SKIP: begin
          skip_reg[hit_idx] <= 1'b1;
        end
        CFE_OP_CLR_SKIP: begin
          skip_reg <= '0;
        end
        default: begin
        end
      endcase
    end else if (state_reg == ST_BIST) begin
      valid_reg[bist_idx_reg] <= 1'b0;
      skip_reg[bist_idx_reg] <= 1'b0;
    end
  end

  // Entry contents
  always_ff @(posedge i_mclk) begin
    if (state_reg == ST_EXEC && gate_ok_reg && op_reg == CFE_OP_WRITE) begin
      cam_key[free_idx] <= comp_reg;
      cam_mask[free_idx] <= mask_reg;
      cam_pers[free_idx] <= pers_reg;
    end else if (state_reg == ST_BIST) begin
      // Self test scrubs every entry; contents are lost by design
      cam_key[bist_idx_reg] <= '0;
      cam_mask[bist_idx_reg] <= '0;
      cam_pers[bist_idx_reg] <= '0;
    end
  end

  // ----------------------------------------------------------------
  // Command, operand and signature registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmd_reg <= CFE_CMD_RST;
      sig_reg <= CFE_WORD_RST;
      pers_reg <= '0;
      comp_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (cmd_wr) begin
        cmd_reg <= i_wdata[CFE_CMD_OP_MSB:0];
      end
      if (state_reg == ST_EXEC && gate_ok_reg && op_reg == CFE_OP_READ) begin
        comp_reg <= cam_key[hit_idx];
        mask_reg <= cam_mask[hit_idx];
        pers_reg <= {cam_pers[hit_idx][CFE_PERS_W-1:CFE_PERS_SKIP + 1],
          skip_reg[hit_idx], valid_reg[hit_idx]};
      end else if (state_reg == ST_EXEC && op_reg == CFE_OP_BIST) begin
        sig_reg <= CFE_SIG_SEED;
      end else if (state_reg == ST_BIST) begin
        // Signature folds each visited index into a rotating word
        sig_reg <= {sig_reg[14:0], sig_reg[15]} ^ {11'h0, bist_idx_reg};
      end else if (i_wr_en && state_reg == ST_IDLE) begin
        case (i_reg_sel)
          CFE_REG_SIG: sig_reg <= i_wdata;
          CFE_REG_PERS: pers_reg <= i_wdata[CFE_PERS_W-1:0];
          CFE_REG_COMP0: comp_reg[15:0] <= i_wdata;
          CFE_REG_COMP1: comp_reg[31:16] <= i_wdata;
          CFE_REG_COMP2: comp_reg[47:32] <= i_wdata;
          CFE_REG_MASK0: mask_reg[15:0] <= i_wdata;
          CFE_REG_MASK1: mask_reg[31:16] <= i_wdata;
          CFE_REG_MASK2: mask_reg[47:32] <= i_wdata;
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Registered read: data follows the select by one clock
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_reg <= CFE_WORD_RST;
    end else begin
      case (i_reg_sel)
        CFE_REG_CMD: rdata_reg <= {13'h0, cmd_reg};
        CFE_REG_STAT: rdata_reg <= {flags_reg, CFE_REVISION, 5'h0};
        CFE_REG_SIG: rdata_reg <= sig_reg;
        CFE_REG_PERS: rdata_reg <= {10'h0, pers_reg};
        CFE_REG_COMP0: rdata_reg <= comp_reg[15:0];
        CFE_REG_COMP1: rdata_reg <= comp_reg[31:16];
        CFE_REG_COMP2: rdata_reg <= comp_reg[47:32];
        CFE_REG_MASK0: rdata_reg <= mask_reg[15:0];
        CFE_REG_MASK1: rdata_reg <= mask_reg[31:16];
        CFE_REG_MASK2: rdata_reg <= mask_reg[47:32];
        default: rdata_reg <= CFE_WORD_RST;
      endcase
    end
  end

  assign o_rdata = rdata_reg;
  assign o_done = flags_reg.done;

endmodule : cfe_engine

// ==== sim/cfe_engine_chk.sv ====
// Checker for the CAM filter command engine, port relations only.
// Assumes one clock and the async active-high reset of the engine.
`timescale 1ns/1ps
module cfe_engine_chk
  import cfe_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [3:0] i_reg_sel,
  input wire logic i_wr_en,
  input wire logic [15:0] i_wdata,
  input wire logic i_rx_match_busy,
  input wire logic [15:0] o_rdata,
  input wire logic o_done
);
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // Idle command write drops done, then finishes; bound covers self test
  a_cmd_runs_done: assert property (
    i_wr_en && i_reg_sel == CFE_REG_CMD && o_done && !i_rx_match_busy
    |=> ##[0:1] !o_done ##[1:40] o_done) else $error("command did not run");
  // Without a write nothing may pull done low
  a_done_holds: assert property (o_done && !i_wr_en |=> o_done)
    else $error("done fell with no write");
  a_reset_vals: assert property (
    $fell(i_rst) |-> o_done && o_rdata == 16'h0000) else $error("bad reset outputs");
  a_cmd_rsvd_zero: assert property (
    $past(i_reg_sel) == CFE_REG_CMD |-> o_rdata[15:3] == 13'h0000)
    else $error("reserved command bits set");
  a_cmd_readback: assert property (
    i_wr_en && i_reg_sel == CFE_REG_CMD ##1 i_reg_sel == CFE_REG_CMD && !i_wr_en
    |=> o_rdata == ($past(i_wdata, 2) & 16'h0007)) else $error("op code readback");
  // Receive-bus compare wins; done must stay up
  a_busy_refused: assert property (
    i_wr_en && i_reg_sel == CFE_REG_CMD && i_rx_match_busy |=> o_done[*3])
    else $error("busy command not refused");
  a_stat_low_bits: assert property (
    $past(i_reg_sel) == CFE_REG_STAT && !$past(i_rst)
    |-> o_rdata[7:0] == {CFE_REVISION, 5'h00}) else $error("status low byte");
  a_stat_done_bit: assert property (
    $past(i_reg_sel) == CFE_REG_STAT && !$past(i_rst) |-> o_rdata[15] == $past(o_done))
    else $error("status done bit");
endmodule : cfe_engine_chk

bind cfe_engine cfe_engine_chk i_chk(.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_sel(i_reg_sel),
  .i_wr_en(i_wr_en), .i_wdata(i_wdata), .i_rx_match_busy(i_rx_match_busy),
  .o_rdata(o_rdata), .o_done(o_done));

// ==== sim/cfe_np_model.sv ====
// Node processor model: register writes, reads and command issue.
// Assumes read data one cycle after the select edge.
`timescale 1ns/1ps
module cfe_np_model
  import cfe_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_done,
  input wire logic [15:0] i_rdata,
  output logic [3:0] o_reg_sel,
  output logic o_wr_en,
  output logic [15:0] o_wdata
);
  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  initial begin
    o_reg_sel = 4'h0;
    o_wr_en = 1'b0;
    o_wdata = 16'h0000;
  end
  // Data inverted on release so stale values never look valid
  task automatic wr(input logic [3:0] sel, input logic [15:0] d);
    @(posedge i_mclk);
    o_reg_sel <= sel;
    o_wdata <= d;
    o_wr_en <= 1'b1;
    @(posedge i_mclk);
    o_wr_en <= 1'b0;
    o_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] sel, output logic [15:0] d);
    @(posedge i_mclk);
    o_reg_sel <= sel;
    @(posedge i_mclk);
    #1 d = i_rdata;
  endtask : rd
  // Caller loads operands first; waits bounded for done both sides
  task automatic cmd(input logic [15:0] d);
    int n;
    n = 0;
    while (i_done !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1 n++;
    end
    wr(CFE_REG_CMD, d);
    repeat (2) @(posedge i_mclk);
    #1 n = 0;
    while (i_done !== 1'b1 && n < 100) begin
      @(posedge i_mclk);
      #1 n++;
    end
  endtask : cmd
endmodule : cfe_np_model

// ==== sim/cam_filter_command_engine_tb.sv ====
// Self-checking bench for the CAM filter command engine.
// Assumes the engine, its package and the node processor model.
`timescale 1ns/1ps
module cam_filter_command_engine_tb;
  import cfe_pkg::*;
  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  logic i_mclk;
  logic i_rst;
  logic i_rx_match_busy;
  logic busy_pick;
  logic [7:0] exp_f;
  logic [3:0] reg_sel;
  logic wr_en;
  logic [15:0] wdata;
  logic [15:0] o_rdata;
  logic o_done;
  logic [15:0] rv;
  logic [47:0] key [32];
  logic [2:0] pers [32];
  int bad_count = 0;
  int total_checks = 0;
  int k;
  initial i_mclk = 1'b0;
  always #20 i_mclk = ~i_mclk;
  cfe_engine i_dut(.i_mclk(i_mclk), .i_rst(i_rst), .i_reg_sel(reg_sel), .i_wr_en(wr_en),
    .i_wdata(wdata), .i_rx_match_busy(i_rx_match_busy), .o_rdata(o_rdata), .o_done(o_done));
  cfe_np_model i_np(.i_mclk(i_mclk), .i_done(o_done), .i_rdata(o_rdata), .o_reg_sel(reg_sel),
    .o_wr_en(wr_en), .o_wdata(wdata));
  // Status word: flags done..self-test, then fixed revision
  function automatic logic [15:0] stat_word(input logic [7:0] f);
    return {f, CFE_REVISION, 5'h00};
  endfunction : stat_word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic stat_is(input logic [7:0] f);
    i_np.rd(CFE_REG_STAT, rv);
    chk(rv, stat_word(f), "status");
  endtask : stat_is
  task automatic find(input logic [47:0] v);
    i_np.wr(CFE_REG_COMP0, v[15:0]);
    i_np.wr(CFE_REG_COMP1, v[31:16]);
    i_np.wr(CFE_REG_COMP2, v[47:32]);
    i_np.cmd(16'h0004);
  endtask : find
  task automatic put(input int i, input logic [15:0] m0);
    find(key[i]);
    i_np.wr(CFE_REG_MASK0, m0);
    i_np.wr(CFE_REG_MASK1, 16'hffff);
    i_np.wr(CFE_REG_MASK2, 16'hffff);
    i_np.wr(CFE_REG_PERS, {13'h0000, pers[i]});
    i_np.cmd(16'h0001);
  endtask : put
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #(40 * 20000);
    bad_count++;
    end_of_test();
  end
  initial begin
    i_rst = 1'b1;
    i_rx_match_busy = 1'b0;
    void'($urandom(32'h76d3));
    for (int i = 0; i < 32; i++) begin
      key[i] = 48'({$urandom(), $urandom()});
      pers[i] = {1'($urandom()), 2'b01};
    end
    key[31] = key[1];
    pers[1] = 3'b001;
    pers[31] = 3'b101;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    i_np.rd(CFE_REG_CMD, rv);
    chk(rv, 16'h0000, "cmd reset");
    stat_is(8'h82);
    i_np.cmd({13'($urandom()), 3'h7});
    i_np.rd(CFE_REG_CMD, rv);
    chk(rv, 16'h0007, "cmd readback");
    put(0, 16'hfffe);
    stat_is(8'h80);
    for (int i = 1; i < 32; i++) put(i, 16'hffff);
    stat_is(8'hc0);
    put(2, 16'hffff);
    stat_is(8'hc4);
    find(key[1]);
    stat_is(8'hf8);
    i_np.cmd(16'h0002);
    stat_is(8'hc0);
    for (int r = 0; r < 3; r++) begin
      i_np.rd(4'(CFE_REG_COMP0 + r), rv);
      chk(rv, key[1][16*r +: 16], "read entry");
    end
    i_np.rd(CFE_REG_PERS, rv);
    chk(rv & 16'h0007, 16'h0001, "read pers");
    find(key[0] ^ 48'h1);
    stat_is({3'b111, pers[0][2], 4'h0});
    find(key[3]);
    i_np.cmd(16'h0006);
    stat_is(8'hc0);
    find(key[3]);
    stat_is(8'hc0);
    i_np.cmd(16'h0005);
    stat_is(8'hc4);
    i_np.cmd(16'h0002);
    stat_is(8'hc4);
    i_np.cmd(16'h0007);
    stat_is(8'hc0);
    find(key[3]);
    stat_is({3'b111, pers[3][2], 4'h0});
    i_np.cmd(16'h0005);
    stat_is(8'h80);
    find(key[3]);
    stat_is(8'h80);
    // Command during a receive-bus compare must be turned away
    @(posedge i_mclk);
    i_rx_match_busy <= 1'b1;
    i_np.cmd(16'h0004);
    i_rx_match_busy <= 1'b0;
    stat_is(8'h84);
    // Random finds, some turned away by a receive-bus compare; those set error and keep the other flags
    exp_f = 8'h84;
    repeat (6) begin
      k = $urandom_range(30, 4);
      busy_pick = 1'($urandom());
      @(posedge i_mclk);
      i_rx_match_busy <= busy_pick;
      find(key[k]);
      i_rx_match_busy <= 1'b0;
      exp_f = busy_pick ? (exp_f | 8'h84) : {3'b101, pers[k][2], 4'h0};
      stat_is(exp_f);
    end
    i_np.cmd(16'h0000);
    stat_is(8'h82);
    i_np.cmd(16'h0003);
    i_np.rd(CFE_REG_STAT, rv);
    chk(rv & 16'h8100, 16'h8100, "self test");
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    stat_is(8'h82);
    end_of_test();
  end
endmodule : cam_filter_command_engine_tb
